//--- rtl/cte_pkg.sv
`default_nettype none
package cte_pkg;
  // object dictionary indices of the entries kept here
  localparam logic [15:0] IDX_ERR_CLASS  = 16'h1001;
  localparam logic [15:0] IDX_MFR_STATUS = 16'h1002;
  localparam logic [15:0] IDX_MFR_MAP    = 16'h301F;
  localparam logic [15:0] IDX_TPDO2_COMM = 16'h1801;
  localparam logic [15:0] IDX_TPDO1_MAP  = 16'h1A00;
  localparam logic [15:0] IDX_TPDO2_MAP  = 16'h1A01;
  localparam logic [15:0] IDX_NMT_START  = 16'h1F80;
  // subindices of the transmit pdo communication record
  localparam logic [7:0]  SUB_TX_TYPE    = 8'h02;
  localparam logic [7:0]  SUB_INHIBIT    = 8'h03;
  localparam logic [7:0]  SUB_EVT_TIMER  = 8'h05;
  // error class bit positions
  localparam int ECB_GENERIC = 0;
  localparam int ECB_CURRENT = 1;
  localparam int ECB_VOLTAGE = 2;
  localparam int ECB_TEMP    = 3;
  localparam int ECB_COMM    = 4;
  localparam int ECB_PROFILE = 5;
  localparam int ECB_MFR     = 7;
  // manufacturer status bit positions
  localparam int MSB_XTILT_X = 0;
  localparam int MSB_XTILT_Y = 1;
  localparam int MSB_RANGE_X = 2;
  localparam int MSB_RANGE_Y = 3;
  localparam int MSB_T_LOW   = 4;
  localparam int MSB_T_HIGH  = 5;
  localparam int MSB_PWR_NOW = 6;
  localparam int MSB_PWR_MEM = 7;
  localparam int MSB_EEPROM  = 8;
  localparam int MSB_FLASH   = 9;
  localparam int MSB_SENSOR  = 10;
  localparam int MSB_WDOG    = 11;
  localparam int MSB_HANDLER = 12;
  // transmission type codes
  localparam logic [7:0]  TT_SYNC  = 8'h01;
  localparam logic [7:0]  TT_EVENT = 8'hFF;
  // reset values
  localparam logic [7:0]  RST_TX_TYPE    = 8'hFF;
  localparam logic [15:0] RST_INHIBIT    = 16'h0000;
  localparam logic [15:0] RST_EVT_TIMER  = 16'h0064;
  localparam logic [7:0]  RST_T1_CNT_1AX = 8'h01;
  localparam logic [7:0]  RST_T1_CNT_2AX = 8'h02;
  localparam logic [7:0]  RST_T2_CNT     = 8'h00;
  localparam logic [31:0] RST_T1_MAP1    = 32'h60100010;
  localparam logic [31:0] RST_T1_MAP2    = 32'h60200010;
  localparam logic [31:0] RST_T2_MAP1    = 32'h64010110;
  localparam logic [31:0] RST_T2_MAP2    = 32'h64010210;
  localparam logic [31:0] RST_T2_MAP3    = 32'h64010310;
  localparam logic [31:0] RST_ZERO32     = 32'h00000000;
  localparam logic [31:0] NMT_PREOP      = 32'h00000004;
  localparam logic [31:0] NMT_OPER       = 32'h00000000;
  // event timer tick: 1 ms at 200 MHz
  localparam int CLK_HZ       = 200000000;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = CLK_HZ / 1000000 * TICK_US;
  // inhibit time unit of 100 us
  localparam int INH_US       = 100;
  localparam int INH_CYCLES   = CLK_HZ / 1000000 * INH_US;
endpackage : cte_pkg
`default_nettype wire

//--- rtl/cte_od_bank.sv
`default_nettype none
module cte_od_bank #(
  parameter bit DUAL_AXIS = 1'b1, // dual-axis model selects two mapped objects
  parameter bit RANGE_90  = 1'b1  // 90-degree model with out-of-range tilt
) (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  // object dictionary access from the protocol stack
  input  wire  logic        od_wr,
  input  wire  logic        od_rd,
  input  wire  logic [15:0] od_index,
  input  wire  logic [7:0]  od_sub,
  input  wire  logic [31:0] od_wdata,
  output logic [31:0]       od_rdata,
  output logic              od_ack,
  output logic              od_abort,
  // raw fault inputs, levels
  input  wire  logic        lat_beyond_45,
  input  wire  logic        lon_beyond_45,
  input  wire  logic        lon_beyond_90,
  input  wire  logic        lat_beyond_90,
  input  wire  logic        temp_low,
  input  wire  logic        temp_high,
  input  wire  logic        power_fault,
  input  wire  logic        eeprom_fault,
  input  wire  logic        flash_fault,
  input  wire  logic        sensor_fault,
  input  wire  logic        watchdog_fault,
  input  wire  logic        handler_active,
  input  wire  logic        current_fault,
  input  wire  logic        comm_fault,
  input  wire  logic        profile_fault,
  // transmit triggers
  input  wire  logic        sync_rx,
  input  wire  logic        internal_event,
  // status outputs
  output logic [7:0]        err_class,
  output logic [31:0]       mfr_status,
  output logic              lon_axis_off,
  output logic              lat_axis_off,
  output logic              tpdo2_send,
  output logic              start_preop
);

  // access handshake in short: a request is a one-cycle pulse on od_wr or
  // od_rd, with index, subindex and write data valid at that same edge
  // the answer comes exactly one cycle later as an od_ack pulse, with
  // od_rdata and, for a refused access, od_abort beside it
  // nothing here is ever busy, so requests may follow back to back
  // limitation: settings live only in these flip-flops; keeping them over
  // a power cycle is the job of the store logic outside this block
  // the class byte and the status word are registered copies of the fault
  // inputs, one cycle behind them, and are never written over the bus

  // configuration entries
  // mapping tables are flip-flops indexed by subindex minus one
  logic [7:0]  tx_type_q;     // pdo2 transmission type
  logic [15:0] inhibit_q;     // pdo2 inhibit time, 100 us units
  logic [15:0] evt_timer_q;   // pdo2 event timer, ms
  logic [7:0]  t1_cnt_q;      // pdo1 mapping count
  logic [7:0]  t2_cnt_q;      // pdo2 mapping count
  logic [31:0] t1_map_q [4];  // pdo1 mapping entries
  logic [31:0] t2_map_q [4];  // pdo2 mapping entries
  logic [31:0] nmt_q;         // start-up selector
  logic        pwr_mem_q;     // memorised power fault
  logic [31:0] mfr_q;         // registered status word
  logic [7:0]  cls_q;         // registered class byte

  // timers
  logic [17:0] tick_cnt_q;    // cycles inside one ms
  logic [15:0] ms_cnt_q;      // elapsed ms of event period
  logic [15:0] inh_cnt_q;     // inhibit cycles left, 100 us units
  logic [15:0] inh_sub_q;     // cycles inside one inhibit unit
  logic        pend_q;        // transmission waiting for inhibit
  logic        send_q;        // one-cycle send pulse

  // combined next value of the status word
  logic [31:0] mfr_d;
  logic [7:0]  cls_d;
  logic        ms_tick;
  logic        timer_hit;

  // subindexes 1 to 4 address a mapping entry
  // subindex 0, the count, is decoded apart by every caller
  function automatic logic map_sub_ok(input logic [7:0] s);
    map_sub_ok = (s <= 8'h04);
  endfunction : map_sub_ok

  // fault word assembly; cross tilt and range cases follow the tilt inputs
  // a tilt past 45 degrees on one axis makes the other axis unusable, so
  // the cross tilt flag of that other axis is raised; on the 90-degree
  // model a single axis past range also raises the other axis' cross tilt
  always_comb begin
    mfr_d = 32'h00000000; // upper bits stay zero
    // longitudinal axis off because of lateral tilt
    mfr_d[cte_pkg::MSB_XTILT_X] = lat_beyond_45 |
                                  (RANGE_90 & lat_beyond_90 & ~lon_beyond_90);
    // lateral axis off because of longitudinal tilt
    mfr_d[cte_pkg::MSB_XTILT_Y] = lon_beyond_45 |
                                  (RANGE_90 & lon_beyond_90 & ~lat_beyond_90);
    mfr_d[cte_pkg::MSB_RANGE_X] = RANGE_90 & lon_beyond_90;
    mfr_d[cte_pkg::MSB_RANGE_Y] = RANGE_90 & lat_beyond_90;
    // both axes beyond range: only the range bits remain
    if (RANGE_90 && lon_beyond_90 && lat_beyond_90) begin
      mfr_d[cte_pkg::MSB_XTILT_X] = 1'b0;
      mfr_d[cte_pkg::MSB_XTILT_Y] = 1'b0;
    end
    // temperature, present power and internal faults are plain levels; the power memory bit holds
    mfr_d[cte_pkg::MSB_T_LOW]   = temp_low;
    mfr_d[cte_pkg::MSB_T_HIGH]  = temp_high;
    mfr_d[cte_pkg::MSB_PWR_NOW] = power_fault;
    mfr_d[cte_pkg::MSB_PWR_MEM] = pwr_mem_q | power_fault;
    mfr_d[cte_pkg::MSB_EEPROM]  = eeprom_fault;
    mfr_d[cte_pkg::MSB_FLASH]   = flash_fault;
    mfr_d[cte_pkg::MSB_SENSOR]  = sensor_fault;
    mfr_d[cte_pkg::MSB_WDOG]    = watchdog_fault;
    mfr_d[cte_pkg::MSB_HANDLER] = handler_active;
  end

  // class byte derived from the same faults; bit 6 is never driven
  // the maker class bit takes the next status word, so the class byte and
  // the status word change on the same edge and never disagree
  always_comb begin
    cls_d = 8'h00;
    cls_d[cte_pkg::ECB_CURRENT] = current_fault;
    cls_d[cte_pkg::ECB_VOLTAGE] = power_fault;
    cls_d[cte_pkg::ECB_TEMP]    = temp_low | temp_high;
    cls_d[cte_pkg::ECB_COMM]    = comm_fault;
    cls_d[cte_pkg::ECB_PROFILE] = profile_fault;
    cls_d[cte_pkg::ECB_MFR]     = |mfr_d;
    // the generic bit is worked out last so it sees every other class
    cls_d[cte_pkg::ECB_GENERIC] = |cls_d[7:1];
  end

  // status registers; the power memory clears only on reset
  // no bus write can clear the memory: a master that wants it gone must
  // reset the node, which is the point of a memorised fault
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_mem_q <= 1'b0;
      mfr_q     <= 32'h00000000;
      cls_q     <= 8'h00;
    end else begin
      pwr_mem_q <= pwr_mem_q | power_fault;
      mfr_q     <= mfr_d;
      cls_q     <= cls_d;
    end
  end

  // configuration writes; read-only entries and unknown slots refuse
  // the write lands at the request edge; its answer follows a cycle later
  // no range check on written codes: choosing legal values is the master's
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_type_q   <= cte_pkg::RST_TX_TYPE;
      inhibit_q   <= cte_pkg::RST_INHIBIT;
      evt_timer_q <= cte_pkg::RST_EVT_TIMER;
      t1_cnt_q    <= DUAL_AXIS ? cte_pkg::RST_T1_CNT_2AX : cte_pkg::RST_T1_CNT_1AX;
      t1_map_q[0] <= cte_pkg::RST_T1_MAP1;
      t1_map_q[1] <= cte_pkg::RST_T1_MAP2;
      t1_map_q[2] <= cte_pkg::RST_ZERO32;
      t1_map_q[3] <= cte_pkg::RST_ZERO32;
      t2_cnt_q    <= cte_pkg::RST_T2_CNT;
      t2_map_q[0] <= cte_pkg::RST_T2_MAP1;
      t2_map_q[1] <= cte_pkg::RST_T2_MAP2;
      t2_map_q[2] <= cte_pkg::RST_T2_MAP3;
      t2_map_q[3] <= cte_pkg::RST_ZERO32;
      nmt_q       <= cte_pkg::NMT_OPER;
    end else if (od_wr) begin
      case (od_index)
        // transmit pdo2 communication record; other subindexes are not kept
        cte_pkg::IDX_TPDO2_COMM: begin
          if (od_sub == cte_pkg::SUB_TX_TYPE)   tx_type_q   <= od_wdata[7:0];
          if (od_sub == cte_pkg::SUB_INHIBIT)   inhibit_q   <= od_wdata[15:0];
          if (od_sub == cte_pkg::SUB_EVT_TIMER) evt_timer_q <= od_wdata[15:0];
        end
        // mapping tables: subindex 0 is the count, 1 to 4 the entries
        cte_pkg::IDX_TPDO1_MAP: begin
          if (od_sub == 8'h00) t1_cnt_q <= od_wdata[7:0];
          else if (map_sub_ok(od_sub)) t1_map_q[od_sub[1:0] - 2'h1] <= od_wdata;
        end
        // second table, same layout
        cte_pkg::IDX_TPDO2_MAP: begin
          if (od_sub == 8'h00) t2_cnt_q <= od_wdata[7:0];
          else if (map_sub_ok(od_sub)) t2_map_q[od_sub[1:0] - 2'h1] <= od_wdata;
        end
        // start-up selector has a single subindex
        cte_pkg::IDX_NMT_START: begin
          if (od_sub == 8'h00) nmt_q <= od_wdata;
        end
        default: begin
          // read-only and unknown entries: nothing is stored
        end
      endcase
    end
  end

  // answer decode, registered; unknown entries abort, master must avoid them
  // a refusal is only ever flagged beside an acknowledge, never when idle
  // read data follows the index even without a request; only ack qualifies it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      od_rdata <= 32'h00000000;
      od_ack   <= 1'b0;
      od_abort <= 1'b0;
    end else begin
      od_ack   <= od_rd | od_wr;
      od_abort <= 1'b0;
      od_rdata <= 32'h00000000;
      case (od_index)
        // class byte: read-only, single subindex
        cte_pkg::IDX_ERR_CLASS: begin
          od_rdata <= {24'h000000, cls_q};
          od_abort <= od_wr | (od_rd & (od_sub != 8'h00));
        end
        // status word, at its own index and at the mapping object
        cte_pkg::IDX_MFR_STATUS, cte_pkg::IDX_MFR_MAP: begin
          od_rdata <= mfr_q;
          od_abort <= od_wr | (od_rd & (od_sub != 8'h00));
        end
        // transmit pdo2 communication record
        cte_pkg::IDX_TPDO2_COMM: begin
          case (od_sub)
            cte_pkg::SUB_TX_TYPE:   od_rdata <= {24'h000000, tx_type_q};
            cte_pkg::SUB_INHIBIT:   od_rdata <= {16'h0000, inhibit_q};
            cte_pkg::SUB_EVT_TIMER: od_rdata <= {16'h0000, evt_timer_q};
            default:                od_abort <= od_rd | od_wr;
          endcase
        end
        // first mapping table
        cte_pkg::IDX_TPDO1_MAP: begin
          if (od_sub == 8'h00) od_rdata <= {24'h000000, t1_cnt_q};
          else if (map_sub_ok(od_sub)) od_rdata <= t1_map_q[od_sub[1:0] - 2'h1];
          else od_abort <= od_rd | od_wr;
        end
        // second mapping table
        cte_pkg::IDX_TPDO2_MAP: begin
          if (od_sub == 8'h00) od_rdata <= {24'h000000, t2_cnt_q};
          else if (map_sub_ok(od_sub)) od_rdata <= t2_map_q[od_sub[1:0] - 2'h1];
          else od_abort <= od_rd | od_wr;
        end
        // start-up selector
        cte_pkg::IDX_NMT_START: begin
          od_rdata <= nmt_q;
          od_abort <= (od_rd | od_wr) & (od_sub != 8'h00);
        end
        // anything else is refused
        default: od_abort <= od_rd | od_wr;
      endcase
    end
  end

  // ms tick divider, free running
  // at 200 MHz one ms needs two hundred thousand cycles, hence 18 bits
  // limitation: the divider is not restarted by a timer write, so the first
  // period after a change may come up to one ms short of its setting
  assign ms_tick = (tick_cnt_q == 18'(cte_pkg::TICK_CYCLES - 1));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) tick_cnt_q <= 18'h00000;
    else if (ms_tick) tick_cnt_q <= 18'h00000;
    else tick_cnt_q <= tick_cnt_q + 18'h00001;
  end

  // event period counter; zero period disables timed sends
  // a period written at or below the elapsed count fires at the next tick
  assign timer_hit = ms_tick && (evt_timer_q != 16'h0000) &&
                     (ms_cnt_q + 16'h0001 >= evt_timer_q);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) ms_cnt_q <= 16'h0000;
    else if (evt_timer_q == 16'h0000 || timer_hit) ms_cnt_q <= 16'h0000;
    else if (ms_tick) ms_cnt_q <= ms_cnt_q + 16'h0001;
  end

  // send request: sync in sync mode, event or timer in event mode;
  // held pending while inhibit runs, and a trigger while unmapped leaves nothing pending
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q    <= 1'b0;
      send_q    <= 1'b0;
      inh_cnt_q <= 16'h0000;
      inh_sub_q <= 16'h0000;
    end else begin
      send_q <= 1'b0;
      // inhibit countdown in 100 us units; a pending request waits for zero
      if (inh_cnt_q != 16'h0000) begin
        if (inh_sub_q == 16'(cte_pkg::INH_CYCLES - 1)) begin
          inh_sub_q <= 16'h0000;
          inh_cnt_q <= inh_cnt_q - 16'h0001;
        end else begin
          // still inside the current inhibit unit
          inh_sub_q <= inh_sub_q + 16'h0001;
        end
      end else if (pend_q) begin
        // send now and start the inhibit time from the stored setting
        send_q    <= 1'b1;
        pend_q    <= 1'b0;
        inh_cnt_q <= inhibit_q;
        inh_sub_q <= 16'h0000;
      end
      // a trigger in the cycle of a send must not be lost, so the set
      // stands last and wins over the clear above
      // type 01h answers sync, type FFh events and the timer
      if ((tx_type_q == cte_pkg::TT_SYNC && sync_rx) ||
          (tx_type_q == cte_pkg::TT_EVENT && (internal_event || timer_hit))) begin
        pend_q <= (t2_cnt_q != 8'h00);
      end
    end
  end

  // outputs
  assign err_class    = cls_q;
  assign mfr_status   = mfr_q;
  // the axis-off flags are the cross tilt bits themselves
  assign lon_axis_off = mfr_q[cte_pkg::MSB_XTILT_X];
  assign lat_axis_off = mfr_q[cte_pkg::MSB_XTILT_Y];
  assign tpdo2_send   = send_q;
  // only the pre-operational code asks for a pre-operational start
  assign start_preop  = (nmt_q == cte_pkg::NMT_PREOP);

endmodule : cte_od_bank
`default_nettype wire

//--- tb/cte_od_bank_asserts.sv
`default_nettype none
module cte_od_bank_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register access
  input wire logic        od_wr,
  input wire logic        od_rd,
  input wire logic [15:0] od_index,
  input wire logic        od_ack,
  input wire logic        od_abort,
  // tilt and power inputs
  input wire logic        lat_beyond_45,
  input wire logic        lon_beyond_90,
  input wire logic        lat_beyond_90,
  input wire logic        power_fault,
  // results
  input wire logic [7:0]  err_class,
  input wire logic [31:0] mfr_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // request, then its answer one cycle on
  sequence s_req; od_rd || od_wr; endsequence
  sequence s_ro_wr; od_wr && (od_index == 16'h1001 || od_index == 16'h1002); endsequence
  sequence s_refused; od_ack && od_abort; endsequence
  property p_ack; s_req |=> od_ack; endproperty
  property p_ro; s_ro_wr |=> s_refused; endproperty
  // class byte is derived from the present faults
  property p_generic; err_class[0] == (err_class[7:1] != 7'h00); endproperty
  property p_zero; !err_class[6] && mfr_status[31:13] == 19'h0; endproperty
  property p_mfrcls; mfr_status != 32'h0 |-> ##[0:1] err_class[7]; endproperty
  // power bits: one follows, one remembers until reset
  property p_pwr; 1'b1 |=> mfr_status[6] == $past(power_fault); endproperty
  property p_mem; mfr_status[7] || power_fault |=> mfr_status[7]; endproperty
  // tilt combinations
  property p_both90; lon_beyond_90 && lat_beyond_90 |=> mfr_status[3:0] == 4'hC; endproperty
  property p_lon90; lon_beyond_90 && !lat_beyond_90 |=> mfr_status[2:1] == 2'b11; endproperty
  property p_lat45; lat_beyond_45 && !lon_beyond_90 && !lat_beyond_90 |=> mfr_status[0]; endproperty
  // a refusal never comes without its answer
  property p_abort; od_abort |-> od_ack; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  a_generic: assert property (p_generic) else $error("generic bit wrong");
  a_zero: assert property (p_zero) else $error("reserved bit set");
  a_mfrcls: assert property (p_mfrcls) else $error("maker class bit missing");
  a_pwr: assert property (p_pwr) else $error("power bit not following");
  a_mem: assert property (p_mem) else $error("power memory lost");
  a_both90: assert property (p_both90) else $error("both range wrong");
  a_lon90: assert property (p_lon90) else $error("lon range wrong");
  a_lat45: assert property (p_lat45) else $error("cross tilt missing");
  a_abort: assert property (p_abort) else $error("refusal without answer");
endmodule : cte_od_bank_asserts
bind cte_od_bank cte_od_bank_asserts i_chk (.clk(clk), .sys_rst(sys_rst), .od_wr(od_wr),
  .od_rd(od_rd), .od_index(od_index), .od_ack(od_ack), .od_abort(od_abort),
  .lat_beyond_45(lat_beyond_45), .lon_beyond_90(lon_beyond_90), .lat_beyond_90(lat_beyond_90),
  .power_fault(power_fault), .err_class(err_class), .mfr_status(mfr_status));
`default_nettype wire

//--- tb/cte_master_model.sv
`default_nettype none
module cte_master_model (
  // clock
  input  wire logic        clk,
  // request fields
  output logic             od_wr,
  output logic             od_rd,
  output logic [55:0]      od_req,
  // answer fields
  input  wire logic [31:0] od_rdata,
  input  wire logic        od_ack,
  input  wire logic        od_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    od_wr = 1'b0;
    od_rd = 1'b0;
    od_req = 56'h0;
  end
  // one-cycle request; released fields are inverted so nothing stale looks valid
  task automatic xfer(input logic w, input logic [55:0] r, output logic [31:0] q,
                      output logic ab, output logic ok);
    @(negedge clk);
    od_wr = w;
    od_rd = !w;
    od_req = r;
    @(negedge clk);
    od_wr = 1'b0;
    od_rd = 1'b0;
    od_req = ~r;
    q = od_rdata;
    ab = od_abort;
    ok = od_ack === 1'b1;
  endtask : xfer
endmodule : cte_master_model
`default_nettype wire

//--- tb/canopen_error_status_and_tpdo_config_bench.sv
`default_nettype none
module canopen_error_status_and_tpdo_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, one fault bit per design input
  logic        clk = 1'b0, sys_rst = 1'b1, sync_rx = 1'b0, internal_event = 1'b0;
  logic [14:0] flt = 15'h0000;
  logic [55:0] od_req;
  logic [31:0] od_rdata, mfr_status, q, r, rs = 32'h49;
  logic [7:0]  err_class;
  logic        od_wr, od_rd, od_ack, od_abort, ab, ok;
  logic        lon_axis_off, lat_axis_off, tpdo2_send, start_preop;
  int          n_errors = 0, compares = 0, cyc = 0, pmem = 0;
  // configuration entries and their reset values
  logic [23:0] t_ent [14] = '{24'h180102, 24'h180103, 24'h180105, 24'h1A0000, 24'h1A0001,
    24'h1A0002, 24'h1A0003, 24'h1A0004, 24'h1A0100, 24'h1A0101, 24'h1A0102, 24'h1A0103,
    24'h1A0104, 24'h1F8000};
  logic [31:0] t_def [14] = '{32'hFF, 32'h0, 32'h64, 32'h2, 32'h60100010, 32'h60200010,
    32'h0, 32'h0, 32'h0, 32'h64010110, 32'h64010210, 32'h64010310, 32'h0, 32'h0};
  logic [3:0]  tilt [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hC};
  cte_od_bank #(.DUAL_AXIS(1'b1), .RANGE_90(1'b1)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .od_wr(od_wr), .od_rd(od_rd), .od_index(od_req[55:40]), .od_sub(od_req[39:32]),
    .od_wdata(od_req[31:0]), .od_rdata(od_rdata), .od_ack(od_ack), .od_abort(od_abort),
    .lat_beyond_45(flt[0]), .lon_beyond_45(flt[1]), .lon_beyond_90(flt[2]),
    .lat_beyond_90(flt[3]), .temp_low(flt[4]), .temp_high(flt[5]), .power_fault(flt[6]),
    .eeprom_fault(flt[7]), .flash_fault(flt[8]), .sensor_fault(flt[9]),
    .watchdog_fault(flt[10]), .handler_active(flt[11]), .current_fault(flt[12]),
    .comm_fault(flt[13]), .profile_fault(flt[14]), .sync_rx(sync_rx),
    .internal_event(internal_event), .err_class(err_class), .mfr_status(mfr_status),
    .lon_axis_off(lon_axis_off), .lat_axis_off(lat_axis_off), .tpdo2_send(tpdo2_send),
    .start_preop(start_preop));
  cte_master_model i_master (.clk(clk), .od_wr(od_wr), .od_rd(od_rd), .od_req(od_req),
    .od_rdata(od_rdata), .od_ack(od_ack), .od_abort(od_abort));
  always #2.5 clk = ~clk;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  // reference status word; a single axis beyond 90 also disables the other
  function automatic logic [31:0] exp_st(input logic [14:0] f);
    logic [31:0] s;
    s = 32'h0;
    if (f[2] && f[3]) s[3:0] = 4'hC;
    else if (f[2]) s[3:0] = 4'h6;
    else if (f[3]) s[3:0] = 4'h9;
    else s[1:0] = {f[1], f[0]};
    s[12:4] = {f[11:7], pmem != 0, f[6:4]};
    return s;
  endfunction : exp_st
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask : chk_b
  // one register access and the abort flag expected with its answer
  task automatic acc(input logic w, input logic [23:0] e, input logic [31:0] d, input logic x);
    i_master.xfer(w, {e, d}, q, ab, ok);
    chk_b(ok, 1'b1);
    chk_b(ab, x);
  endtask : acc
  task automatic chk_defaults();
    for (int k = 0; k < 14; k++) begin
      acc(1'b0, t_ent[k], 32'h0, 1'b0);
      chk_w(q, t_def[k]);
    end
  endtask : chk_defaults
  // 8-bit entries get legal codes, 16-bit ones random low halves
  task automatic rw_all();
    logic [31:0] w;
    for (int k = 0; k < 14; k++) begin
      r = xs();
      w = (k == 0 || k == 3 || k == 8) ? 32'h1 : (k < 3) ? {16'h0, r[15:0]} : r;
      if (k == 13) w = 32'h4;
      acc(1'b1, t_ent[k], w, 1'b0);
      acc(1'b0, t_ent[k], 32'h0, 1'b0);
      chk_w(q, w);
    end
  endtask : rw_all
  // count transmissions after a single trigger pulse
  task automatic pulse(input logic sy, input int expn);
    int n;
    n = 0;
    @(negedge clk);
    sync_rx = sy;
    internal_event = !sy;
    for (int k = 0; k < 9; k++) begin
      @(negedge clk);
      sync_rx = 1'b0;
      internal_event = 1'b0;
      n += int'(tpdo2_send === 1'b1);
    end
    chk_w(n, expn);
  endtask : pulse
  task automatic fstep(input logic [14:0] f);
    logic [31:0] s;
    flt = f;
    if (f[6]) pmem = 1;
    s = exp_st(f);
    repeat (2) @(negedge clk);
    chk_w(mfr_status, s);
    chk_w({30'h0, lat_axis_off, lon_axis_off}, {30'h0, s[1:0]});
    r = {24'h0, s != 0, 1'b0, f[14:13], f[5] | f[4], f[6], f[12], 1'b0};
    r[0] = r[7:1] != 0;
    chk_w({24'h0, err_class}, r);
    acc(1'b0, 24'h301F00, 32'h0, 1'b0);
    chk_w(q, s);
  endtask : fstep
  task automatic end_sim();
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk_defaults();
    rw_all();
    chk_b(start_preop, 1'b1);
    acc(1'b1, 24'h1F8000, 32'h0, 1'b0);
    chk_b(start_preop, 1'b0);
    acc(1'b1, 24'h100100, rs, 1'b1);
    acc(1'b1, 24'h100200, rs, 1'b1);
    acc(1'b0, 24'h200000, 32'h0, 1'b1);
    acc(1'b0, 24'h180104, 32'h0, 1'b1);
    acc(1'b1, 24'h180103, 32'h0, 1'b0);
    pulse(1'b0, 0);
    pulse(1'b1, 1);
    acc(1'b1, 24'h180102, 32'hFF, 1'b0);
    pulse(1'b0, 1);
    acc(1'b1, 24'h1A0100, 32'h0, 1'b0);
    pulse(1'b0, 0);
    acc(1'b1, 24'h1A0100, 32'h1, 1'b0);
    acc(1'b1, 24'h180103, 32'h1, 1'b0);
    pulse(1'b0, 1);
    pulse(1'b0, 0);
    repeat (40) begin
      r = xs();
      fstep({r[14:4], tilt[int'(r[31:29]) % 6]});
    end
    fstep(15'h0040);
    fstep(15'h0000);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    pmem = 0;
    fstep(15'h0000);
    chk_defaults();
    end_sim();
  end
endmodule : canopen_error_status_and_tpdo_config_bench
`default_nettype wire
